// file: src/pwm_pkg.sv
// Shared constants and types for the buffered PWM duty stepper
package pwm_pkg;

    // ********************************************************************
    // Widths
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 16;
    localparam int STEP_W = 5;
    localparam int CTRL_W = 4;

    // ********************************************************************
    // Register offsets (byte addresses)
    // ********************************************************************
    localparam logic [ADDR_W-1:0] CTRL_OFFSET     = 8'h00;
    localparam logic [ADDR_W-1:0] PERIOD_OFFSET   = 8'h04;
    localparam logic [ADDR_W-1:0] DUTY_CMP_OFFSET = 8'h08;
    localparam logic [ADDR_W-1:0] AUX_OFFSET      = 8'h0C;
    localparam logic [ADDR_W-1:0] DUTY_BUF_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] COUNTER_OFFSET  = 8'h14;
    localparam logic [ADDR_W-1:0] STEP_OFFSET     = 8'h18;

    // ********************************************************************
    // Control field positions and reset values
    // ********************************************************************
    localparam int CTRL_RUN_BIT      = 0;
    localparam int CTRL_TICK_RUN_BIT = 1;
    localparam int CTRL_SEQ_EN_BIT   = 2;
    localparam int CTRL_PIN_OE_BIT   = 3;

    localparam logic [CTRL_W-1:0] CTRL_RESET   = 4'h0;
    localparam logic [CNT_W-1:0]  PERIOD_RESET = 16'h0C7F;
    localparam logic [CNT_W-1:0]  DUTY_RESET   = 16'h013F;
    localparam logic [CNT_W-1:0]  AUX_RESET    = 16'h0000;

    // ********************************************************************
    // Duty table and step index
    // ********************************************************************
    localparam logic [CNT_W-1:0]  DUTY_TBL_BASE  = 16'h013F;
    localparam logic [CNT_W-1:0]  DUTY_TBL_STEP  = 16'h0140;
    localparam logic [STEP_W-1:0] STEP_DEC_START = 5'h00;
    localparam logic [STEP_W-1:0] STEP_DEC_ZERO  = 5'h09;
    localparam logic [STEP_W-1:0] STEP_INC_START = 5'h0A;
    localparam logic [STEP_W-1:0] STEP_INC_END   = 5'h12;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_HZ         = 125_000_000;
    localparam int STEP_PERIOD_MS = 10;
    localparam int TICK_PRESCALE  = 8;
    localparam int TICK_COUNT     = CLK_HZ / TICK_PRESCALE / 1000 * STEP_PERIOD_MS;

    // ********************************************************************
    // Bus responses and sequencer states
    // ********************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEQ_DEC = 2'b01,
        SEQ_INC = 2'b10
    } seq_state_type;

endpackage

// file: src/interval_timer.sv
// Interval timer: clock prescaler and reload counter giving a periodic tick
`timescale 1ns/1ps
module interval_timer #(
    parameter int PRESCALE = 8,
    parameter int RELOAD   = 156250
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic run,
    output logic      tick
);
    localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
    localparam int CW = (RELOAD > 1) ? $clog2(RELOAD) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(RELOAD - 1);

    logic [PW-1:0] pre_q;
    logic [CW-1:0] cnt_q;
    logic          tick_q;
    logic          pre_tick;

    assign pre_tick = run && (pre_q == PRE_LAST);
    assign tick     = tick_q;

    // Count source is the clock divided by the prescale
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            pre_q <= '0;
        end else if (pre_q == PRE_LAST) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Plain timer mode: count down, reload and tick on underflow
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_q <= CNT_LAST;
        end else if (pre_tick) begin
            cnt_q <= (cnt_q == '0) ? CNT_LAST : cnt_q - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= pre_tick && (cnt_q == '0);
        end
    end

endmodule

// file: src/buffered_pwm_duty_stepper.sv
// PWM generator with buffered duty compare and a timed duty sequencer
//
// Notes on behaviour
// - Counter advances one step per clock
// - Counter clears when it matches period compare
// - Period lasts period compare plus one steps
// - Output active low, idles high
// - High duty+1 steps, low period-duty steps
// - Software writes duty into the buffer register
// - Period compare written directly, never buffered
// - Duty table: 319 up to 2879, step 320
// - Every tick: 90% down to 0%, alternate
// - Tick from clock/8 interval timer, no pin
// - Step index: 0 decrease, 10 increase, 17 wraps back to 10
// - Waveform drives the output pin as output
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module buffered_pwm_duty_stepper
    import pwm_pkg::*;
#(
    parameter int TICK_RELOAD = pwm_pkg::TICK_COUNT
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pwm_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [pwm_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    output logic                            pwm_out_pin,
    output logic                            pwm_out_oe
);
    import pwm_pkg::*;

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0]  period_compare_reg;
    logic [CNT_W-1:0]  duty_compare_reg;
    logic [CNT_W-1:0]  aux_compare_reg;
    logic [CNT_W-1:0]  duty_buffer_reg;
    logic [CNT_W-1:0]  pwm_counter;
    logic              pwm_out_q;

    logic [ADDR_W-1:0] aw_addr_q;
    logic              aw_have_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              w_have_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    logic              wr_fire;
    logic              wr_hit;
    logic [31:0]       rd_word;
    logic              rd_hit;

    logic              pwm_run;
    logic              period_match;
    logic              step_tick;
    seq_state_type     seq_state_q;
    seq_state_type     seq_state_d;
    logic [STEP_W-1:0] step_q;
    logic [STEP_W-1:0] step_d;
    logic [CNT_W-1:0]  table_value;

    assign pwm_run      = ctrl_q[CTRL_RUN_BIT];
    assign period_match = (pwm_counter == period_compare_reg);

    // ********************************************************************
    // Byte-lane merge for 16-bit registers
    // ********************************************************************
    function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
        logic [CNT_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v;
    endfunction

    // ********************************************************************
    // AXI4-Lite write channels
    // ********************************************************************
    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wvalid && wready) begin
            w_have_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_addr_q)
            CTRL_OFFSET, PERIOD_OFFSET, AUX_OFFSET, DUTY_BUF_OFFSET,
            DUTY_CMP_OFFSET, COUNTER_OFFSET, STEP_OFFSET: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ********************************************************************
    // AXI4-Lite read channels
    // ********************************************************************
    assign arready = !rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        unique case (araddr)
            CTRL_OFFSET: begin
                rd_word[CTRL_W-1:0] = ctrl_q;
            end
            PERIOD_OFFSET: begin
                rd_word[CNT_W-1:0] = period_compare_reg;
            end
            DUTY_CMP_OFFSET: begin
                rd_word[CNT_W-1:0] = duty_compare_reg;
            end
            AUX_OFFSET: begin
                rd_word[CNT_W-1:0] = aux_compare_reg;
            end
            DUTY_BUF_OFFSET: begin
                rd_word[CNT_W-1:0] = duty_buffer_reg;
            end
            COUNTER_OFFSET: begin
                rd_word[CNT_W-1:0] = pwm_counter;
            end
            STEP_OFFSET: begin
                rd_word[STEP_W-1:0] = step_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ********************************************************************
    // Software registers
    // ********************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_fire && aw_addr_q == CTRL_OFFSET && w_strb_q[0]) begin
            ctrl_q <= w_data_q[CTRL_W-1:0];
        end
    end

    // Period compare has no buffer: a write takes effect at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_compare_reg <= PERIOD_RESET;
        end else if (wr_fire && aw_addr_q == PERIOD_OFFSET) begin
            period_compare_reg <= merge16(period_compare_reg, w_data_q, w_strb_q);
        end
    end

    // Auxiliary compare is plain storage, not a buffer for the period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_compare_reg <= AUX_RESET;
        end else if (wr_fire && aw_addr_q == AUX_OFFSET) begin
            aux_compare_reg <= merge16(aux_compare_reg, w_data_q, w_strb_q);
        end
    end

    // Buffer takes software writes; a sequencer step in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_buffer_reg <= DUTY_RESET;
        end else if (step_tick && ctrl_q[CTRL_SEQ_EN_BIT]) begin
            duty_buffer_reg <= table_value;
        end else if (wr_fire && aw_addr_q == DUTY_BUF_OFFSET) begin
            duty_buffer_reg <= merge16(duty_buffer_reg, w_data_q, w_strb_q);
        end
    end

    // ********************************************************************
    // PWM counter, compare and output
    // ********************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || !pwm_run) begin
            pwm_counter <= '0;
        end else if (period_match) begin
            pwm_counter <= '0;
        end else begin
            pwm_counter <= pwm_counter + 1'b1;
        end
    end

    // While stopped the compare tracks the buffer so a start uses it at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_compare_reg <= DUTY_RESET;
        end else if (!pwm_run || period_match) begin
            duty_compare_reg <= duty_buffer_reg;
        end
    end

    // High while counter is at or below duty, low for the rest
    always_ff @(posedge aclk) begin
        if (!aresetn || !pwm_run) begin
            pwm_out_q <= 1'b1;
        end else begin
            pwm_out_q <= (pwm_counter <= duty_compare_reg);
        end
    end

    assign pwm_out_pin = pwm_out_q;
    assign pwm_out_oe  = ctrl_q[CTRL_PIN_OE_BIT];

    // ********************************************************************
    // Duty step timer and sequencer
    // ********************************************************************
    interval_timer #(
        .PRESCALE (TICK_PRESCALE),
        .RELOAD   (TICK_RELOAD)
    ) u_interval_timer (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (ctrl_q[CTRL_TICK_RUN_BIT]),
        .tick     (step_tick)
    );

    always_comb begin
        step_d      = step_q + 1'b1;
        seq_state_d = seq_state_q;
        if (step_d == STEP_INC_END) begin
            step_d = STEP_INC_START;
        end
        unique case (seq_state_q)
            SEQ_DEC: begin
                if (step_d == STEP_INC_START) begin
                    seq_state_d = SEQ_INC;
                end
            end
            SEQ_INC: begin
                seq_state_d = SEQ_INC;
            end
            default: begin
                seq_state_d = SEQ_DEC;
            end
        endcase
    end

    // Value for the index being entered; 0% duty is a compare at the period
    always_comb begin
        table_value = period_compare_reg;
        if (seq_state_d == SEQ_DEC && step_d < STEP_DEC_ZERO) begin
            table_value = DUTY_TBL_BASE + CNT_W'(step_d) * DUTY_TBL_STEP;
        end else if (seq_state_d == SEQ_INC && !step_d[0]) begin
            table_value = DUTY_TBL_BASE + CNT_W'(STEP_DEC_ZERO - 1'b1) * DUTY_TBL_STEP;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_q[CTRL_SEQ_EN_BIT]) begin
            step_q      <= STEP_DEC_START;
            seq_state_q <= SEQ_DEC;
        end else if (step_tick) begin
            step_q      <= step_d;
            seq_state_q <= seq_state_d;
        end
    end

endmodule

// file: verif/pwm_stepper_monitor.sv
// Bus and pin checker for the PWM duty stepper
`timescale 1ns/1ps
module pwm_stepper_monitor #(
    parameter int TICK_RELOAD = 4
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       awvalid,
    input wire logic                       awready,
    input wire logic                       wvalid,
    input wire logic                       wready,
    input wire logic [1:0]                 bresp,
    input wire logic                       bvalid,
    input wire logic                       bready,
    input wire logic [pwm_pkg::ADDR_W-1:0] araddr,
    input wire logic                       arvalid,
    input wire logic                       arready,
    input wire logic [31:0]                rdata,
    input wire logic [1:0]                 rresp,
    input wire logic                       rvalid,
    input wire logic                       rready,
    input wire logic                       pwm_out_pin,
    input wire logic                       pwm_out_oe
);
    import pwm_pkg::*;
    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_idle_pin: assert property (disable iff (1'b0) !aresetn |=> pwm_out_pin && !pwm_out_oe)
        else $error("pin not idle after reset");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    chk_resp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_data_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    chk_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    chk_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    chk_unmapped_read: assert property (arvalid && arready && araddr > STEP_OFFSET
        |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused");

    cover property (awvalid && awready && wvalid && wready);
    cover property (arvalid && arready && araddr > STEP_OFFSET);
    cover property ($fell(pwm_out_pin));
endmodule

bind buffered_pwm_duty_stepper pwm_stepper_monitor #(.TICK_RELOAD(TICK_RELOAD)) u_monitor (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe));

// file: verif/pwm_load_model.sv
// Load on the PWM pin: measures the last high and low run lengths
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic   aclk,
    input wire logic   pin,
    input wire logic   oe,
    output logic [15:0] high_len,
    output logic [15:0] low_len
);
    logic [15:0] run_q;
    logic        level_q;

    initial begin
        high_len = 16'h0000;
        low_len  = 16'h0000;
        run_q    = 16'h0000;
        level_q  = 1'b1;
    end

    // Only a driven pin is measured
    always @(posedge aclk) begin
        if (!oe) begin
            run_q <= 16'h0000;
        end else if (pin === level_q) begin
            run_q <= run_q + 16'h0001;
        end else begin
            if (level_q)
                high_len <= run_q;
            else
                low_len <= run_q;
            run_q <= 16'h0001;
        end
        level_q <= pin;
    end
endmodule

// file: verif/buffered_pwm_duty_stepper_tb.sv
// Self-checking testbench for the buffered PWM duty stepper
`timescale 1ns/1ps
module buffered_pwm_duty_stepper_tb;
    import pwm_pkg::*;
    localparam int TB_TICK_RELOAD = 4;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, pin, oe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got, exp_buf;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, got_resp;
    logic [15:0] high_len, low_len;
    logic [4:0]  exp_step;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          polls;
    int          cyc = 0;
    int          last_cyc = 0;

    buffered_pwm_duty_stepper #(.TICK_RELOAD(TB_TICK_RELOAD)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pwm_out_pin(pin),
        .pwm_out_oe(oe));
    pwm_load_model u_load (.aclk(aclk), .pin(pin), .oe(oe), .high_len(high_len), .low_len(low_len));

    // ********************************************************************
    // Bus tasks
    // ********************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (bvalid && bready) begin
                done = 1;
                got_resp = bresp;
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            bready <= !done && n >= 3;
        end
        check("write response", er, got_resp);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (rvalid && rready) begin
                done = 1;
                got = rdata;
                got_resp = rresp;
            end
            if (arvalid && arready) arvalid <= 1'b0;
            rready <= !done && n >= 2;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        rd(a);
        check($sformatf("read data %h", a), exp, got);
        check($sformatf("read response %h", a), er, got_resp);
    endtask

    task automatic test_done;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ********************************************************************
    // Clock, watchdog and tests
    // ********************************************************************
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Cycle count for timing the duty steps
    always @(posedge aclk) cyc <= cyc + 1;

    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        test_done;
    end

    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = 8'h00;
        araddr  = 8'h00;
        wdata   = 32'h00000000;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        check("idle pin", 32'h00000001, pin);
        check("idle enable", 32'h00000000, oe);
        rdc(PERIOD_OFFSET, 32'h00000C7F, RESP_OKAY);
        rdc(DUTY_BUF_OFFSET, 32'h0000013F, RESP_OKAY);
        rdc(STEP_OFFSET, 32'h00000000, RESP_OKAY);
        rdc(COUNTER_OFFSET, 32'h00000000, RESP_OKAY);
        rdc(8'h1C, 32'h00000000, RESP_SLVERR);
        wr(8'h1C, 32'h000000FF, RESP_SLVERR);
        wr(DUTY_CMP_OFFSET, 32'h00000005, RESP_OKAY);
        rdc(DUTY_CMP_OFFSET, 32'h0000013F, RESP_OKAY);
        wr(AUX_OFFSET, 32'h0000ABCD, RESP_OKAY);
        rdc(AUX_OFFSET, 32'h0000ABCD, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h00000009, RESP_OKAY);
        check("pin enable", 32'h00000001, oe);
        repeat (7000) @(posedge aclk);
        check("high steps", 32'h00000140, high_len);
        check("low steps", 32'h00000B40, low_len);
        wr(DUTY_BUF_OFFSET, 32'h0000027F, RESP_OKAY);
        rdc(DUTY_CMP_OFFSET, 32'h0000013F, RESP_OKAY);
        repeat (7000) @(posedge aclk);
        rdc(DUTY_CMP_OFFSET, 32'h0000027F, RESP_OKAY);
        check("high steps", 32'h00000280, high_len);
        check("low steps", 32'h00000A00, low_len);
        wr(CTRL_OFFSET, 32'h00000000, RESP_OKAY);
        wr(PERIOD_OFFSET, 32'h00000003, RESP_OKAY);
        wr(DUTY_BUF_OFFSET, 32'h00000001, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h00000009, RESP_OKAY);
        repeat (20) @(posedge aclk);
        check("high steps", 32'h00000002, high_len);
        check("low steps", 32'h00000002, low_len);
        wr(DUTY_BUF_OFFSET, 32'h00000002, RESP_OKAY);
        repeat (20) @(posedge aclk);
        check("high steps", 32'h00000003, high_len);
        check("low steps", 32'h00000001, low_len);
        wr(CTRL_OFFSET, 32'h00000000, RESP_OKAY);
        wr(PERIOD_OFFSET, 32'h00000C7F, RESP_OKAY);
        wr(CTRL_OFFSET, 32'h0000000F, RESP_OKAY);
        exp_step = 5'h00;
        for (int i = 0; i < 20; i++) begin
            polls = 0;
            do begin
                rd(STEP_OFFSET);
                polls++;
            end while (got[4:0] === exp_step && polls < 40);
            exp_step = (exp_step == 5'h11) ? 5'h0A : exp_step + 5'h01;
            check("step index", {27'h0, exp_step}, got);
            if (i > 0)
                check("tick spacing", TB_TICK_RELOAD * TICK_PRESCALE, cyc - last_cyc);
            last_cyc = cyc;
            if (exp_step <= 5'h08)
                exp_buf = 32'h0000013F + 32'h00000140 * exp_step;
            else if (exp_step == 5'h09 || exp_step[0])
                exp_buf = 32'h00000C7F;
            else
                exp_buf = 32'h00000B3F;
            rdc(DUTY_BUF_OFFSET, exp_buf, RESP_OKAY);
        end
        test_done;
    end
endmodule
